//--- hdl/key_list_mem.v
`timescale 1ns/10ps
`include "rx_status_map.vh"
module key_list_mem (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire clr,
   input wire wr,
   input wire [7:0] wr_data,
   input wire rd,
   output wire [7:0] rd_data,
   output wire empty,
   output reg overflow
);
   reg [7:0] mem [0:`KEY_LIST_BYTES-1];
   reg [`KEY_LIST_AW-1:0] wr_ptr_r;
   reg [`KEY_LIST_AW-1:0] rd_ptr_r;
   reg [`KEY_LIST_AW:0] count_r;
   wire full;
   wire do_wr;
   wire do_rd;

   assign full = (count_r == {1'b1, {`KEY_LIST_AW{1'b0}}});
   assign empty = (count_r == {(`KEY_LIST_AW+1){1'b0}});
   assign do_wr = wr & ~full;
   assign do_rd = rd & ~empty;
   // Head byte, zero once drained
   assign rd_data = empty ? 8'h00 : mem[rd_ptr_r];

   // Storage array, written by the link side
   always @(posedge clk) begin
      if (ce && do_wr && !clr) begin
         mem[wr_ptr_r] <= wr_data;
      end
   end

   // Pointers and fill level; clear restarts a new list
   always @(posedge clk) begin
      if (srst) begin
         wr_ptr_r <= {`KEY_LIST_AW{1'b0}};
         rd_ptr_r <= {`KEY_LIST_AW{1'b0}};
         count_r <= {(`KEY_LIST_AW+1){1'b0}};
         overflow <= 1'b0;
      end else if (ce) begin
         overflow <= wr & full & ~clr;
         if (clr) begin
            wr_ptr_r <= {`KEY_LIST_AW{1'b0}};
            rd_ptr_r <= {`KEY_LIST_AW{1'b0}};
            count_r <= {(`KEY_LIST_AW+1){1'b0}};
         end else begin
            if (do_wr) begin
               wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
               rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
               count_r <= count_r + 1'b1;
            end else if (do_rd && !do_wr) begin
               count_r <= count_r - 1'b1;
            end
         end
      end
   end
endmodule // key_list_mem

//--- hdl/level_sync.v
`timescale 1ns/10ps
module level_sync (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire din,
   output wire dout
);
   reg meta_r;
   reg sync_r;

   // Two flops; only the second is read
   always @(posedge clk) begin
      if (srst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else if (ce) begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end

   assign dout = sync_r;
endmodule // level_sync

//--- hdl/rx_status_regs.v
`timescale 1ns/10ps
`include "rx_status_map.vh"
module rx_status_regs (
   input wire clk,
   input wire srst,
   input wire ce,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg irq,
   // Receiver key vector ready, arrives from outside this clock
   input wire rx_key_ready,
   // Transmitter key bytes from the key store
   input wire tx_key_load,
   input wire [7:0] tx_key_byte3_in,
   input wire [7:0] tx_key_byte4_in,
   // Capability byte relayed over the link
   input wire caps_load,
   input wire [7:0] caps_in,
   // Topology status relayed over the link
   input wire topo_load,
   input wire [6:0] device_count_in,
   input wire device_limit_in,
   input wire [3:0] cascade_depth_in,
   input wire cascade_limit_in,
   // Key list bytes relayed over the link
   input wire list_clear,
   input wire list_wr,
   input wire [7:0] list_wr_data
);
   // Stored status
   reg [7:0] tx_key3_r;
   reg [7:0] tx_key4_r;
   reg [7:0] caps_r;
   reg dev_err_r;
   reg [6:0] dev_count_r;
   reg casc_err_r;
   reg [2:0] casc_depth_r;

   // Event machinery
   reg [7:0] evt_status_r;
   reg [7:0] evt_status_nxt;
   reg [7:0] evt_mask_r;
   reg [7:0] evt_mask_nxt;
   reg [7:0] evt_set;
   reg key_ready_d_r;

   // Read path
   reg [7:0] rdata_nxt;
   reg list_pop;

   // Topology and capability next values
   reg dev_err_nxt;
   reg [6:0] dev_count_nxt;
   reg casc_err_nxt;
   reg [2:0] casc_depth_nxt;
   reg [7:0] caps_nxt;

   wire key_ready_s;
   wire [7:0] list_head;
   wire list_empty;
   wire list_ovf;
   wire repeater_seen;
   wire [7:0] caps_view;
   wire [7:0] topo_lo_view;
   wire [7:0] topo_hi_view;

   // Ready flag from another domain
   level_sync u_key_ready_sync (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .din(rx_key_ready),
      .dout(key_ready_s)
   );

   // Key list storage behind the list port
   key_list_mem u_key_list (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .clr(list_clear),
      .wr(list_wr),
      .wr_data(list_wr_data),
      .rd(list_pop),
      .rd_data(list_head),
      .empty(list_empty),
      .overflow(list_ovf)
   );

   // Transmitter key bytes 3 and 4, loaded from the key store
   always @(posedge clk) begin
      if (srst) begin
         tx_key3_r <= `RST_TX_KEY;
         tx_key4_r <= `RST_TX_KEY;
      end else if (ce && tx_key_load) begin
         tx_key3_r <= tx_key_byte3_in;
         tx_key4_r <= tx_key_byte4_in;
      end
   end

   // Capability byte: only implemented bits are kept
   always @* begin
      caps_nxt = caps_r;
      if (caps_load) begin
         caps_nxt[`CAPS_REPEATER] = caps_in[`CAPS_REPEATER];
         caps_nxt[`CAPS_LIST_READY] = caps_in[`CAPS_LIST_READY];
         // Kept for software only, the link carries control traffic
         caps_nxt[`CAPS_FAST_2W] = caps_in[`CAPS_FAST_2W];
         caps_nxt[`CAPS_ENH_SIGNAL] = caps_in[`CAPS_ENH_SIGNAL];
         caps_nxt[`CAPS_QUICK_REAUTH] = caps_in[`CAPS_QUICK_REAUTH];
         caps_nxt = caps_nxt & `CAPS_USED_MASK;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         caps_r <= `RST_CAPS;
      end else if (ce) begin
         caps_r <= caps_nxt;
      end
   end

   // Repeater flag as it stands after a capability load in this cycle
   assign repeater_seen = caps_nxt[`CAPS_REPEATER];

   // Topology checks done on the incoming values
   always @* begin
      dev_err_nxt = dev_err_r;
      dev_count_nxt = dev_count_r;
      casc_err_nxt = casc_err_r;
      casc_depth_nxt = casc_depth_r;
      if (topo_load) begin
         // Error on relayed flag or a count beyond the list depth
         dev_err_nxt = device_limit_in | (device_count_in > `MAX_DEVS);
         // A plain receiver reports no downstream devices
         dev_count_nxt = repeater_seen ? device_count_in : 7'h00;
         casc_err_nxt = cascade_limit_in | (cascade_depth_in > `CASC_MAX);
         if (cascade_depth_in > `CASC_MAX) begin
            casc_depth_nxt = 3'h7;
         end else begin
            casc_depth_nxt = cascade_depth_in[2:0];
         end
      end else if (caps_load && !repeater_seen) begin
         dev_count_nxt = 7'h00;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         dev_err_r <= 1'b0;
         dev_count_r <= 7'h00;
         casc_err_r <= 1'b0;
         casc_depth_r <= 3'h0;
      end else if (ce) begin
         dev_err_r <= dev_err_nxt;
         dev_count_r <= dev_count_nxt;
         casc_err_r <= casc_err_nxt;
         casc_depth_r <= casc_depth_nxt;
      end
   end

   // Register views; reserved bits read zero
   assign caps_view = {1'b0,
      caps_r[`CAPS_REPEATER] & key_ready_s,
      caps_r[`CAPS_LIST_READY],
      caps_r[`CAPS_FAST_2W],
      2'b00,
      caps_r[`CAPS_ENH_SIGNAL],
      caps_r[`CAPS_QUICK_REAUTH]};
   assign topo_lo_view = {dev_err_r, dev_count_r};
   assign topo_hi_view = {4'h0, casc_err_r, casc_depth_r};

   // Read decode; unmapped offsets return zero
   always @* begin
      rdata_nxt = 8'h00;
      list_pop = 1'b0;
      if (reg_rd) begin
         case (reg_addr)
            `ADDR_TX_KEY3: begin
               rdata_nxt = tx_key3_r;
            end
            `ADDR_TX_KEY4: begin
               rdata_nxt = tx_key4_r;
            end
            `ADDR_CAPS: begin
               rdata_nxt = caps_view;
            end
            `ADDR_TOPO_LO: begin
               rdata_nxt = topo_lo_view;
            end
            `ADDR_TOPO_HI: begin
               rdata_nxt = topo_hi_view;
            end
            `ADDR_KEY_LIST: begin
               rdata_nxt = list_head;
               list_pop = ~list_empty;
            end
            `ADDR_EVT_STATUS: begin
               rdata_nxt = evt_status_r;
            end
            `ADDR_EVT_MASK: begin
               rdata_nxt = evt_mask_r;
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         reg_rdata <= rdata_nxt;
      end
   end

   // Edge memory for the synchronised ready flag
   always @(posedge clk) begin
      if (srst) begin
         key_ready_d_r <= 1'b0;
      end else if (ce) begin
         key_ready_d_r <= key_ready_s;
      end
   end

   // Events raised by status changes
   always @* begin
      evt_set = 8'h00;
      evt_set[`EVT_CAPS] = caps_load;
      evt_set[`EVT_TOPO] = topo_load;
      evt_set[`EVT_LIST_READY] = caps_nxt[`CAPS_LIST_READY]
         & ~caps_r[`CAPS_LIST_READY];
      evt_set[`EVT_TOPO_ERR] = topo_load & (dev_err_nxt | casc_err_nxt);
      evt_set[`EVT_LIST_OVF] = list_ovf;
      evt_set[`EVT_KEY_READY] = key_ready_s & ~key_ready_d_r;
   end

   // Sticky status cleared by a read, a new event wins over the clear
   always @* begin
      if (reg_rd && reg_addr == `ADDR_EVT_STATUS) begin
         evt_status_nxt = evt_set;
      end else begin
         evt_status_nxt = evt_status_r | evt_set;
      end
   end

   // Mask is the only writable register; all others ignore writes
   always @* begin
      evt_mask_nxt = evt_mask_r;
      if (reg_wr && reg_addr == `ADDR_EVT_MASK) begin
         evt_mask_nxt = reg_wdata & `EVT_USED_MASK;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         evt_status_r <= 8'h00;
         evt_mask_r <= `RST_EVT_MASK;
         irq <= 1'b0;
      end else if (ce) begin
         evt_status_r <= evt_status_nxt;
         evt_mask_r <= evt_mask_nxt;
         irq <= |(evt_status_nxt & evt_mask_nxt);
      end
   end
endmodule // rx_status_regs

//--- inc/rx_status_map.vh
`ifndef RX_STATUS_MAP_VH
`define RX_STATUS_MAP_VH

// Register offsets
`define ADDR_TX_KEY3 8'h93
`define ADDR_TX_KEY4 8'h94
`define ADDR_CAPS 8'ha0
`define ADDR_TOPO_LO 8'ha1
`define ADDR_TOPO_HI 8'ha2
`define ADDR_KEY_LIST 8'ha3
`define ADDR_EVT_STATUS 8'ha4
`define ADDR_EVT_MASK 8'ha5

// Reset values
`define RST_TX_KEY 8'h00
`define RST_CAPS 8'h00
`define RST_TOPO 8'h00
`define RST_EVT_MASK 8'h00

// Capability field positions and the implemented bits
`define CAPS_REPEATER 6
`define CAPS_LIST_READY 5
`define CAPS_FAST_2W 4
`define CAPS_ENH_SIGNAL 1
`define CAPS_QUICK_REAUTH 0
`define CAPS_USED_MASK 8'h73

// Topology field positions and limits
`define TOPO_DEV_ERR 7
`define TOPO_CASC_ERR 3
`define CASC_MAX 4'h7
`define MAX_DEVS 7'd25

// Key list storage
`define KEY_LIST_AW 7
`define KEY_LIST_BYTES 128

// Event bits of the status and mask registers
`define EVT_CAPS 0
`define EVT_TOPO 1
`define EVT_LIST_READY 2
`define EVT_TOPO_ERR 3
`define EVT_LIST_OVF 4
`define EVT_KEY_READY 5
`define EVT_USED_MASK 8'h3f
`endif

//--- testbench/rx_link_model.sv
`timescale 1ns/10ps
module rx_link_model (
   input wire clk,
   output reg caps_load,
   output reg [7:0] caps_in,
   output reg topo_load,
   output reg [6:0] device_count_in,
   output reg device_limit_in,
   output reg [3:0] cascade_depth_in,
   output reg cascade_limit_in,
   output reg list_clear,
   output reg list_wr,
   output reg [7:0] list_wr_data
);
   // Link quiet at start
   initial begin
      {caps_load, topo_load, list_clear, list_wr} = 4'h0;
      {caps_in, device_count_in, device_limit_in} = 16'h0000;
      {cascade_depth_in, cascade_limit_in, list_wr_data} = 13'h0000;
   end
   // Each relay drops its data to the inverse once the strobe ends
   task send_caps(input [7:0] b);
      caps_in <= b;
      caps_load <= 1'b1;
      @(posedge clk);
      caps_load <= 1'b0;
      caps_in <= ~b;
   endtask
   task send_topo(input [12:0] t);
      {device_count_in, device_limit_in, cascade_depth_in, cascade_limit_in} <= t;
      topo_load <= 1'b1;
      @(posedge clk);
      topo_load <= 1'b0;
      {device_count_in, device_limit_in, cascade_depth_in, cascade_limit_in} <= ~t;
   endtask
   task clear_list;
      list_clear <= 1'b1;
      @(posedge clk);
      list_clear <= 1'b0;
   endtask
   task send_list(input logic [7:0] q[$]);
      foreach (q[i]) begin
         list_wr_data <= q[i];
         list_wr <= 1'b1;
         @(posedge clk);
      end
      list_wr <= 1'b0;
      list_wr_data <= ~list_wr_data;
   endtask
endmodule // rx_link_model

//--- testbench/rx_status_chk.sv
`timescale 1ns/10ps
`include "rx_status_map.vh"
module rx_status_chk (
   input wire clk,
   input wire srst,
   input wire [7:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire irq,
   input wire rx_key_ready,
   input wire tx_key_load,
   input wire [7:0] tx_key_byte3_in,
   input wire [7:0] tx_key_byte4_in,
   input wire caps_load,
   input wire [7:0] caps_in,
   input wire topo_load,
   input wire [6:0] device_count_in,
   input wire device_limit_in,
   input wire [3:0] cascade_depth_in,
   input wire cascade_limit_in,
   input wire list_clear
);
   // Expected fields worked out from the link inputs
   wire dev_err = device_limit_in || (device_count_in > 7'h19);
   wire casc_err = cascade_limit_in || (cascade_depth_in > 4'h7);
   wire [2:0] casc_sat = (cascade_depth_in > 4'h7) ? 3'h7 : cascade_depth_in[2:0];
   wire [7:0] caps_low = caps_in & 8'h33;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_key_byte3: assert property (tx_key_load ##1 (reg_rd && reg_addr == 8'h93)
      |=> reg_rdata == $past(tx_key_byte3_in, 2)) else $error("key byte 3 wrong");
   a_key_byte4: assert property (tx_key_load ##1 (reg_rd && reg_addr == 8'h94)
      |=> reg_rdata == $past(tx_key_byte4_in, 2)) else $error("key byte 4 wrong");
   a_caps_bits: assert property (caps_load ##1 (reg_rd && reg_addr == 8'ha0)
      |=> (reg_rdata & 8'hbf) == $past(caps_low, 2)) else $error("capability bits wrong");
   a_repeater_gate: assert property ((!rx_key_ready) [*4] ##0
      (reg_rd && reg_addr == 8'ha0) |=> !reg_rdata[6]) else $error("repeater bit ungated");
   a_device_err: assert property (topo_load ##1 (reg_rd && reg_addr == 8'ha1)
      |=> reg_rdata[7] == $past(dev_err, 2)) else $error("device limit flag wrong");
   a_cascade_field: assert property (topo_load ##1 (reg_rd && reg_addr == 8'ha2)
      |=> reg_rdata == {4'h0, $past(casc_err, 2), $past(casc_sat, 2)})
      else $error("cascade status wrong");
   a_list_cleared: assert property (list_clear ##1 (reg_rd && reg_addr == 8'ha3)
      |=> reg_rdata == 8'h00) else $error("cleared list not empty");
   c_list_read: cover property (reg_rd && reg_addr == 8'ha3);
   c_irq_rise: cover property ($rose(irq));
   c_topo_read: cover property (topo_load ##1 reg_rd);
endmodule // rx_status_chk
bind rx_status_regs rx_status_chk u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .rx_key_ready(rx_key_ready),
   .tx_key_load(tx_key_load), .tx_key_byte3_in(tx_key_byte3_in),
   .tx_key_byte4_in(tx_key_byte4_in), .caps_load(caps_load), .caps_in(caps_in),
   .topo_load(topo_load), .device_count_in(device_count_in),
   .device_limit_in(device_limit_in), .cascade_depth_in(cascade_depth_in),
   .cascade_limit_in(cascade_limit_in), .list_clear(list_clear));

//--- testbench/tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module tb;
   logic clk = 1'b0, srst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic rx_key_ready = 1'b0, tx_key_load = 1'b0, dl, cl;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, k3 = 8'h00, k4 = 8'h00, c;
   logic [6:0] n;
   logic [3:0] d;
   logic [15:0] note;
   logic [15:0] exp_q[$];
   logic [7:0] lq[$];
   wire [7:0] reg_rdata, caps_in, list_wr_data;
   wire [6:0] device_count_in;
   wire [3:0] cascade_depth_in;
   wire irq, caps_load, topo_load, list_clear, list_wr, device_limit_in, cascade_limit_in;
   int fails = 0, n_compared = 0, cycles = 0;
   rx_status_regs u_rx_status_regs (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .rx_key_ready(rx_key_ready), .tx_key_load(tx_key_load),
      .tx_key_byte3_in(k3), .tx_key_byte4_in(k4), .caps_load(caps_load), .caps_in(caps_in),
      .topo_load(topo_load), .device_count_in(device_count_in),
      .device_limit_in(device_limit_in), .cascade_depth_in(cascade_depth_in),
      .cascade_limit_in(cascade_limit_in), .list_clear(list_clear), .list_wr(list_wr),
      .list_wr_data(list_wr_data));
   rx_link_model u_rx_link_model (.clk(clk), .caps_load(caps_load), .caps_in(caps_in),
      .topo_load(topo_load), .device_count_in(device_count_in),
      .device_limit_in(device_limit_in), .cascade_depth_in(cascade_depth_in),
      .cascade_limit_in(cascade_limit_in), .list_clear(list_clear), .list_wr(list_wr),
      .list_wr_data(list_wr_data));
   always #12.5 clk = ~clk;
   // One bus cycle; strobes stay as set until the next call
   task bus(input r, input w, input [7:0] a, input [7:0] wd);
      reg_rd <= r;
      reg_wr <= w;
      reg_addr <= a;
      reg_wdata <= wd;
      @(posedge clk);
   endtask
   // Read with a note of the expected byte and the bits that matter
   task rd(input [7:0] a, input [7:0] e, input [7:0] m);
      exp_q.push_back({m, e});
      bus(1'b1, 1'b0, a, 8'h00);
   endtask
   task complete_run;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Answer checked in the cycle after the read
   always @(posedge clk) rd_d <= reg_rd;
   always @(negedge clk) begin
      if (rd_d) begin
         note = exp_q.pop_front();
         `CHK(reg_rdata & note[15:8], note[7:0] & note[15:8])
      end
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         complete_run;
      end
   end
   initial begin
      void'($urandom(80325));
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      foreach (lq[i]) lq.delete();
      rd(8'h93, 8'h00, 8'hff);
      rd(8'h94, 8'h00, 8'hff);
      for (int i = 0; i < 5; i++) rd(8'ha0 + i, 8'h00, 8'hff);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      $display("reset values done");
      k3 <= $urandom;
      k4 <= $urandom;
      tx_key_load <= 1'b1;
      @(posedge clk);
      tx_key_load <= 1'b0;
      rd(8'h93, k3, 8'hff);
      bus(1'b0, 1'b1, 8'h93, ~k3);
      rd(8'h93, k3, 8'hff);
      rd(8'h94, k4, 8'hff);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      for (int i = 0; i < 5; i++) begin
         c = (i == 4) ? 8'hff : $urandom;
         if (i == 4) rx_key_ready <= 1'b1;
         if (i == 4) repeat (4) @(posedge clk);
         u_rx_link_model.send_caps(c);
         rd(8'ha0, c & ((i == 4) ? 8'h73 : 8'h33), 8'hff);
         bus(1'b0, 1'b0, 8'h00, 8'h00);
      end
      $display("capability done");
      for (int i = 0; i < 8; i++) begin
         n = (i == 1) ? 7'h19 : (i == 2) ? 7'h1a : $urandom_range(0, 40);
         d = (i == 1) ? 4'h7 : (i == 2) ? 4'h8 : $urandom_range(0, 9);
         dl = $urandom;
         cl = $urandom;
         if (i == 4) u_rx_link_model.send_caps(8'h00);
         u_rx_link_model.send_topo({n, dl, d, cl});
         rd(8'ha1, {dl || n > 25, (i < 4) ? n : 7'h00}, (i < 4) ? 8'hff : 8'h7f);
         rd(8'ha2, {4'h0, cl || d > 7, (d > 7) ? 3'h7 : d[2:0]}, 8'hff);
         bus(1'b0, 1'b0, 8'h00, 8'h00);
      end
      $display("topology done");
      u_rx_link_model.clear_list;
      for (int i = 0; i < 6; i++) lq.push_back($urandom);
      u_rx_link_model.send_list(lq);
      foreach (lq[i]) rd(8'ha3, lq[i], 8'hff);
      rd(8'ha3, 8'h00, 8'hff);
      rd(8'ha4, 8'h00, 8'h00);
      bus(1'b0, 1'b1, 8'ha5, 8'h01);
      u_rx_link_model.send_caps(8'h12);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      @(negedge clk);
      `CHK(irq, 1'b1)
      @(posedge clk);
      rd(8'ha4, 8'h01, 8'h01);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      @(negedge clk);
      `CHK(irq, 1'b0)
      $display("list and event done");
      repeat (3) @(posedge clk);
      complete_run;
   end
endmodule // tb
